// ==== hw/asf_pkg.sv ====
// Constants, field layout and types shared by the accelerometer sample buffer
package asf_pkg;

  // Buffer geometry
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int LVL_W = 7;
  localparam int AXIS_W = 16;
  localparam int WORD_W = 48;
  localparam int THR_W = 6;

  // Register offsets on the serial host bus
  localparam logic [7:0] ADR_EVT_FLAGS = 8'h0A;
  localparam logic [7:0] ADR_FILL = 8'h0D;
  localparam logic [7:0] ADR_POLICY = 8'h14;
  localparam logic [7:0] ADR_AXIS = 8'h15;
  localparam logic [7:0] ADR_IRQ_EN = 8'h17;
  localparam logic [7:0] ADR_IRQ_ROUTE = 8'h1A;
  localparam logic [7:0] ADR_READ_PORT = 8'hFF;

  // Values after reset
  localparam logic [7:0] RST_POLICY = 8'h20;
  localparam logic [7:0] RST_AXIS = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_IRQ_ROUTE = 8'h00;

  // Writable bits of each register
  localparam logic [7:0] MASK_AXIS = 8'h03;
  localparam logic [7:0] MASK_IRQ_EN = 8'h60;
  localparam logic [7:0] MASK_IRQ_ROUTE = 8'h06;

  // Field positions
  localparam int POLICY_LSB = 6;
  localparam int BIT_FULL_FLAG = 2;
  localparam int BIT_THR_FLAG = 1;
  localparam int BIT_FULL_EN = 6;
  localparam int BIT_THR_EN = 5;
  localparam int BIT_FULL_ROUTE = 2;
  localparam int BIT_THR_ROUTE = 1;

  // Capacity and full-event counts per policy
  localparam logic [LVL_W-1:0] CAP_PASS = 7'h01;
  localparam logic [LVL_W-1:0] CAP_FULL = 7'h40;
  localparam logic [LVL_W-1:0] FULL_CNT_STOP = 7'h40;
  localparam logic [LVL_W-1:0] FULL_CNT_OVW = 7'h3F;
  localparam logic [LVL_W-1:0] FULL_CNT_PASS = 7'h01;
  localparam logic [LVL_W-1:0] SINCE_MAX = 7'h7F;

  // Bytes per stored sample
  localparam logic [2:0] BYTES_ALL = 3'h6;
  localparam logic [2:0] BYTES_ONE = 3'h2;

  // Host bus device address; value is arbitrary
  localparam logic [6:0] HOST_ADDR = 7'h1D;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  typedef enum logic [1:0] {
    POL_PASS = 2'h0,
    POL_STOP = 2'h1,
    POL_OVW = 2'h2,
    POL_TRIG = 2'h3
  } asf_policy_e;

  typedef enum logic [1:0] {
    SEL_XYZ = 2'h0,
    SEL_X = 2'h1,
    SEL_Y = 2'h2,
    SEL_Z = 2'h3
  } asf_axis_e;

endpackage

// ==== hw/asf_mem_if.sv ====
// Carrier between the buffer controller and its sample memory
`timescale 1ns/1ps
interface asf_mem_if;
  import asf_pkg::*;
  logic we;
  logic [PTR_W-1:0] waddr;
  logic [WORD_W-1:0] wdata;
  logic [PTR_W-1:0] raddr;
  logic [WORD_W-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== hw/asf_sample_mem.sv ====
// Sample storage with registered read data
`timescale 1ns/1ps
module asf_sample_mem import asf_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Controller side
  asf_mem_if.mem port
);

  logic [WORD_W-1:0] mem_r [DEPTH];
  logic [WORD_W-1:0] rdata_r;

  always_ff @(posedge mclk) begin
    if (port.we) begin
      mem_r[port.waddr] <= port.wdata;
    end
  end

  // Read lags the address by one cycle; the host bus is far slower
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem_r[port.raddr];
    end
  end

  assign port.rdata = rdata_r;

endmodule // asf_sample_mem

// ==== hw/asf_sample_fifo.sv ====
// Sample buffer controller with serial host bus register access
// Notes on behaviour
// - Up to 64 samples, x/y/z 16-bit each
// - Pass-through acts as depth-one overwrite buffer
// - Stop-when-full ignores samples once 64 stored
// - Overwrite-oldest drops oldest entry when full
// - Trigger keeps latest, retains n, then stops
// - Trigger ignored after capture; re-arm via pass-through
// - Policy codes 00..11; readback shows current policy
// - Config writes empty buffer, clear both flags
// - Address pointer sticks at the read port
// - Axis select: all, x, y or z
// - Stored values equal the axis data registers
// - Partial sample remainder discarded at read end
// - Empty or past-level reads return zero
// - Fill level counts stored samples, drops on read
// - Full flag sets at the full-event count (64/63/1) or on write while full; sticky
// - Threshold flag when level reaches threshold count
// - Threshold irq needs enable and routing bits
// - Full irq at 64/63/1 samples; enable and route
// - Policy register resets to pass-through, threshold 32
`timescale 1ns/1ps
module asf_sample_fifo import asf_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Serial host bus
  input wire logic scl,
  input wire logic sda,
  output logic sda_q,
  output logic sda_oe,
  // Processed axis samples
  input wire logic smp_valid,
  input wire logic [AXIS_W-1:0] smp_x,
  input wire logic [AXIS_W-1:0] smp_y,
  input wire logic [AXIS_W-1:0] smp_z,
  // Interrupt side
  input wire logic trig_evt,
  input wire logic other_irq,
  input wire logic irq_act_high,
  output logic irq_pin
);

  typedef enum logic [2:0] {S_IDLE, S_DEV, S_REG, S_WDATA, S_ACK, S_RDATA, S_GACK} asf_bus_e;

  asf_mem_if mif ();

  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;
  asf_bus_e st_r, ack_next_r;
  logic [7:0] sh_r, tx_r, ptr_r;
  logic [3:0] cnt_r;
  logic rw_r, nack_r, sda_oe_r;
  logic [7:0] policy_r, axis_r, irq_en_r, route_r;
  logic [PTR_W-1:0] rd_r, wr_r;
  logic [LVL_W-1:0] level_r, since_r;
  logic trig_done_r, full_flag_r, thr_flag_r, irq_pin_r;
  logic [2:0] byte_idx_r;

  logic scl_rise, scl_fall, bus_start, bus_stop, byte_done;
  logic wr_stb, ld_stb, end_xfer, cfg_clr, port_ld;
  logic [7:0] rd_byte, fifo_byte;
  asf_policy_e pol;
  asf_axis_e axis_sel;
  logic [THR_W-1:0] thr;
  logic trig_live, overwrite, pop_req, pop, room, do_wr, drop, trig_hit;
  logic full_set, thr_set, irq_any;
  logic [LVL_W-1:0] cap, lvl_ap, full_cnt, since_nxt;
  logic [2:0] last_byte;
  logic [WORD_W-1:0] smp_word;

  asf_sample_mem u_mem (
    .mclk(mclk),
    .arst_n(arst_n),
    .port(mif.mem)
  );

  // Bus pins come from another clock domain
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= scl;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= sda;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  assign scl_rise = scl_s2_r && !scl_s3_r;
  assign scl_fall = !scl_s2_r && scl_s3_r;
  assign bus_start = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
  assign bus_stop = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
  assign byte_done = scl_fall && (cnt_r == BITS_PER_BYTE);
  assign wr_stb = (st_r == S_WDATA) && byte_done;
  assign ld_stb = scl_fall && (((st_r == S_ACK) && (ack_next_r == S_RDATA)) ||
                               ((st_r == S_GACK) && !nack_r));
  assign end_xfer = bus_start || bus_stop;
  assign port_ld = ld_stb && (ptr_r == ADR_READ_PORT);

  // Host bus slave: receive, acknowledge, transmit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= S_IDLE;
      ack_next_r <= S_IDLE;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      cnt_r <= 4'h0;
      rw_r <= 1'b0;
      nack_r <= 1'b1;
      ptr_r <= 8'h00;
      sda_oe_r <= 1'b0;
    end else if (bus_start) begin
      st_r <= S_DEV;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      st_r <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        S_DEV, S_REG, S_WDATA: begin
          if (scl_rise && (cnt_r != BITS_PER_BYTE)) begin
            sh_r <= {sh_r[6:0], sda_s2_r};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_done) begin
            cnt_r <= 4'h0;
            st_r <= S_ACK;
            sda_oe_r <= 1'b1;
            if (st_r == S_DEV) begin
              rw_r <= sh_r[0];
              ack_next_r <= sh_r[0] ? S_RDATA : S_REG;
              if (sh_r[7:1] != HOST_ADDR) begin
                st_r <= S_IDLE;
                sda_oe_r <= 1'b0;
              end
            end else if (st_r == S_REG) begin
              ptr_r <= sh_r;
              ack_next_r <= S_WDATA;
            end else begin
              ptr_r <= (ptr_r == ADR_READ_PORT) ? ptr_r : ptr_r + 8'h01;
              ack_next_r <= S_WDATA;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            st_r <= ack_next_r;
            cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            if (ack_next_r == S_RDATA) begin
              tx_r <= rd_byte;
              sda_oe_r <= !rd_byte[7];
              ptr_r <= (ptr_r == ADR_READ_PORT) ? ptr_r : ptr_r + 8'h01;
            end
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == LAST_TX_BIT) begin
              st_r <= S_GACK;
              sda_oe_r <= 1'b0;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= !tx_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        S_GACK: begin
          if (scl_rise) begin
            nack_r <= sda_s2_r;
          end else if (scl_fall) begin
            cnt_r <= 4'h0;
            if (nack_r) begin
              st_r <= S_IDLE;
            end else begin
              st_r <= S_RDATA;
              tx_r <= rd_byte;
              sda_oe_r <= !rd_byte[7];
              ptr_r <= (ptr_r == ADR_READ_PORT) ? ptr_r : ptr_r + 8'h01;
            end
          end
        end
      endcase
    end
  end

  assign sda_q = 1'b0;
  assign sda_oe = sda_oe_r;

  // Configuration registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      policy_r <= RST_POLICY;
      axis_r <= RST_AXIS;
      irq_en_r <= RST_IRQ_EN;
      route_r <= RST_IRQ_ROUTE;
    end else if (wr_stb) begin
      unique case (ptr_r)
        ADR_POLICY: policy_r <= sh_r;
        ADR_AXIS: axis_r <= sh_r & MASK_AXIS;
        ADR_IRQ_EN: irq_en_r <= sh_r & MASK_IRQ_EN;
        ADR_IRQ_ROUTE: route_r <= sh_r & MASK_IRQ_ROUTE;
        default: ;
      endcase
    end
  end

  assign cfg_clr = wr_stb && ((ptr_r == ADR_POLICY) || (ptr_r == ADR_AXIS));
  assign pol = asf_policy_e'(policy_r[POLICY_LSB +: 2]);
  assign thr = policy_r[THR_W-1:0];
  assign axis_sel = asf_axis_e'(axis_r[1:0]);

  // Before capture trigger policy behaves as overwrite-oldest, afterwards as stop-when-full
  assign trig_live = (pol == POL_TRIG) && !trig_done_r;
  assign overwrite = (pol == POL_PASS) || (pol == POL_OVW) || trig_live;
  assign cap = (pol == POL_PASS) ? CAP_PASS : CAP_FULL;
  assign pop = pop_req && (level_r != '0);
  assign lvl_ap = level_r - {6'h00, pop};
  assign room = lvl_ap < cap;
  assign do_wr = smp_valid && (room || overwrite);
  assign drop = smp_valid && !room && overwrite;
  assign trig_hit = trig_evt && trig_live;
  assign since_nxt = (since_r == SINCE_MAX) ? since_r : since_r + {6'h00, smp_valid};

  always_comb begin
    if (pol == POL_PASS) begin
      full_cnt = FULL_CNT_PASS;
    end else if ((pol == POL_OVW) || trig_live) begin
      full_cnt = FULL_CNT_OVW;
    end else begin
      full_cnt = FULL_CNT_STOP;
    end
  end

  // Values arrive already ranged, inverted and swapped like the data registers
  always_comb begin
    unique case (axis_sel)
      SEL_XYZ: smp_word = {smp_z, smp_y, smp_x};
      SEL_X: smp_word = {32'h0000_0000, smp_x};
      SEL_Y: smp_word = {32'h0000_0000, smp_y};
      SEL_Z: smp_word = {32'h0000_0000, smp_z};
    endcase
  end

  assign mif.we = do_wr;
  assign mif.waddr = wr_r;
  assign mif.wdata = smp_word;
  assign mif.raddr = rd_r;

  // Pointers and fill level
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_r <= '0;
      wr_r <= '0;
      level_r <= '0;
      since_r <= '0;
    end else if (cfg_clr) begin
      rd_r <= '0;
      wr_r <= '0;
      level_r <= '0;
      since_r <= '0;
    end else if (trig_hit) begin
      // A sample landing on the trigger cycle is not stored; one sample at most
      if (level_r > {1'b0, thr}) begin
        rd_r <= rd_r + PTR_W'(level_r - {1'b0, thr});
        level_r <= {1'b0, thr};
      end
    end else begin
      wr_r <= wr_r + {5'h00, do_wr};
      rd_r <= rd_r + {5'h00, pop} + {5'h00, drop};
      level_r <= lvl_ap + {6'h00, do_wr && !drop};
      since_r <= since_nxt;
    end
  end

  // Capture state of the trigger policy
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trig_done_r <= 1'b0;
    end else if (trig_hit) begin
      trig_done_r <= 1'b1;
    end else if (wr_stb && (ptr_r == ADR_POLICY) &&
                 (sh_r[POLICY_LSB +: 2] == POL_PASS)) begin
      trig_done_r <= 1'b0;
    end
  end

  // Flags: an event in the clearing cycle still sets the flag
  assign full_set = smp_valid && (!room || (since_r + 7'h01 == full_cnt));
  assign thr_set = (thr != '0) && (level_r == {1'b0, thr});

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      full_flag_r <= 1'b0;
    end else if (full_set) begin
      full_flag_r <= 1'b1;
    end else if (cfg_clr) begin
      full_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      thr_flag_r <= 1'b0;
    end else if (thr_set) begin
      thr_flag_r <= 1'b1;
    end else if (cfg_clr) begin
      thr_flag_r <= 1'b0;
    end
  end

  // Read port: byte walk within a sample and popping
  assign last_byte = ((axis_sel == SEL_XYZ) ? BYTES_ALL : BYTES_ONE) - 3'h1;
  assign fifo_byte = mif.rdata[{byte_idx_r, 3'b000} +: 8];
  // Remainder of a partly read sample goes at the end of the transfer
  assign pop_req = (port_ld && (byte_idx_r == last_byte)) ||
                   (end_xfer && (byte_idx_r != 3'h0));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      byte_idx_r <= 3'h0;
    end else if (cfg_clr) begin
      byte_idx_r <= 3'h0;
    end else if (port_ld && (level_r != '0)) begin
      byte_idx_r <= (byte_idx_r == last_byte) ? 3'h0 : byte_idx_r + 3'h1;
    end else if (end_xfer) begin
      byte_idx_r <= 3'h0;
    end
  end

  always_comb begin
    unique case (ptr_r)
      ADR_EVT_FLAGS: begin
        rd_byte = 8'h00;
        rd_byte[BIT_FULL_FLAG] = full_flag_r;
        rd_byte[BIT_THR_FLAG] = thr_flag_r;
      end
      ADR_FILL: rd_byte = {1'b0, level_r};
      ADR_POLICY: rd_byte = policy_r;
      ADR_AXIS: rd_byte = axis_r;
      ADR_IRQ_EN: rd_byte = irq_en_r;
      ADR_IRQ_ROUTE: rd_byte = route_r;
      // Reads past the fill level must end within a sampling period
      ADR_READ_PORT: rd_byte = (level_r == '0) ? 8'h00 : fifo_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  // Interrupt pin; reset shows zero until the level choice settles one cycle later
  assign irq_any = (full_flag_r && irq_en_r[BIT_FULL_EN] && route_r[BIT_FULL_ROUTE]) ||
                   (thr_flag_r && irq_en_r[BIT_THR_EN] && route_r[BIT_THR_ROUTE]) ||
                   other_irq;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_pin_r <= 1'b0;
    end else begin
      irq_pin_r <= irq_act_high ? irq_any : !irq_any;
    end
  end

  assign irq_pin = irq_pin_r;

endmodule // asf_sample_fifo

// ==== test/asf_sample_fifo_properties.sv ====
// Port-level assertions for the sample buffer controller
`timescale 1ns/1ps
module asf_fifo_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Bus and interrupt pins
  input wire logic scl,
  input wire logic sda_q,
  input wire logic sda_oe,
  input wire logic other_irq,
  input wire logic irq_act_high,
  input wire logic irq_pin
);
  logic bus_used_r;
  // Until the bus first moves, no enable or routing bit can have been written
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_used_r <= 1'b0;
    end else if (!scl) begin
      bus_used_r <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_other_held;
    other_irq [*2];
  endsequence
  property p_pin_active;
    s_other_held |=> irq_pin == $past(irq_act_high);
  endproperty
  a_pin_active: assert property (p_pin_active)
    else $error("pin not active while other irq held");
  property p_pin_idle;
    !bus_used_r && !other_irq |=> irq_pin == !$past(irq_act_high);
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("pin active with no routed irq");
  // Flipping the level choice while an irq is held must flip the pin
  property p_pin_flip;
    s_other_held ##0 $changed(irq_act_high) |=> $changed(irq_pin);
  endproperty
  a_pin_flip: assert property (p_pin_flip)
    else $error("pin ignored level change");
  // Open-drain pin: the driven value is always low
  property p_sda_q_low;
    sda_q == 1'b0;
  endproperty
  a_sda_q_low: assert property (p_sda_q_low)
    else $error("sda driven high");
  // The device only starts pulling sda while scl is low
  property p_oe_rise_low;
    $rose(sda_oe) |-> !scl;
  endproperty
  a_oe_rise_low: assert property (p_oe_rise_low)
    else $error("sda pulled while scl high");
  // While scl is high the device may only let sda go
  property p_oe_high_release;
    scl && $changed(sda_oe) |-> !sda_oe;
  endproperty
  a_oe_high_release: assert property (p_oe_high_release)
    else $error("sda changed while scl high");
endmodule // asf_fifo_checker

bind asf_sample_fifo asf_fifo_checker u_chk (.mclk(mclk), .arst_n(arst_n), .scl(scl),
  .sda_q(sda_q), .sda_oe(sda_oe),
  .other_irq(other_irq), .irq_act_high(irq_act_high), .irq_pin(irq_pin));

// ==== test/asf_host_model.sv ====
// Behavioural host that masters the serial register bus
`timescale 1ns/1ps
module asf_host_model import asf_pkg::*; (
  // Bus pins, sda is the resolved wire
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  logic [7:0] rb [0:15];
  logic [7:0] nak;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    nak = 8'h00;
  end
  // Data moves well after scl falls so it never races the clock edge
  task automatic bit_io(input logic b, output logic r);
    #10 sda_pull = !b;
    #110 scl = 1'b1;
    #60 r = sda;
    #20 scl = 1'b0;
  endtask
  // Long low phase lets the device release its acknowledge first
  task automatic start_c();
    #10 sda_pull = 1'b0;
    #190 scl = 1'b1;
    #100 sda_pull = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic stop_c();
    #10 sda_pull = 1'b1;
    #110 scl = 1'b1;
    #100 sda_pull = 1'b0;
    #100;
  endtask
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    if (r) nak++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start_c();
    tx({HOST_ADDR, 1'b0});
    tx(a);
    tx(d);
    stop_c();
  endtask
  // Capture array limits a burst to 16 bytes
  task automatic rd(input logic [7:0] a, input int n);
    logic r;
    start_c();
    tx({HOST_ADDR, 1'b0});
    tx(a);
    start_c();
    tx({HOST_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, r);
        rb[k][i] = r;
      end
      bit_io(k == n - 1, r);
    end
    stop_c();
    #1500;
  endtask
endmodule // asf_host_model

// ==== test/tb.sv ====
// Self-checking bench for the sample buffer controller
`timescale 1ns/1ps
module tb import asf_pkg::*;;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic scl;
  logic sda;
  logic sda_q;
  logic sda_oe;
  logic h_pull;
  logic smp_valid = 1'b0;
  logic [AXIS_W-1:0] smp_x = '0;
  logic [AXIS_W-1:0] smp_y = '0;
  logic [AXIS_W-1:0] smp_z = '0;
  logic trig_evt = 1'b0;
  logic other_irq = 1'b0;
  logic irq_act_high = 1'b1;
  logic irq_pin;
  logic [7:0] sn = 8'h00;
  logic [7:0] hi [0:2] = '{8'hA1, 8'hB2, 8'hC3};
  int err_count = 0;
  int n_checks = 0;
  always #12.5 mclk = ~mclk;
  // Open-drain wire with pull-up
  assign sda = !(h_pull || sda_oe);
  asf_sample_fifo dut (.mclk(mclk), .arst_n(arst_n), .scl(scl), .sda(sda), .sda_q(sda_q),
    .sda_oe(sda_oe), .smp_valid(smp_valid), .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z),
    .trig_evt(trig_evt), .other_irq(other_irq), .irq_act_high(irq_act_high),
    .irq_pin(irq_pin));
  asf_host_model host (.scl(scl), .sda_pull(h_pull), .sda(sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, 1);
    chk(host.rb[0], exp);
  endtask
  task automatic pin_is(input logic v);
    repeat (4) @(posedge mclk);
    chk({7'h00, irq_pin}, {7'h00, v});
  endtask
  // Samples never arrive during a read, so no read spans a sampling period
  task automatic push(input int n);
    repeat (n) begin
      @(posedge mclk);
      smp_valid <= 1'b1;
      smp_x <= {hi[0], sn};
      smp_y <= {hi[1], sn};
      smp_z <= {hi[2], sn};
      @(posedge mclk);
      smp_valid <= 1'b0;
      sn = sn + 8'h01;
    end
  endtask
  task automatic trig();
    @(posedge mclk);
    trig_evt <= 1'b1;
    @(posedge mclk);
    trig_evt <= 1'b0;
  endtask
  task automatic chk_smp(input int k, input logic [7:0] i);
    for (int a = 0; a < 3; a++) begin
      chk(host.rb[k + 2 * a], i);
      chk(host.rb[k + 2 * a + 1], hi[a]);
    end
  endtask
  task automatic cfg(input logic [7:0] d);
    host.wr(ADR_POLICY, d);
    sn = 8'h00;
    rreg(ADR_POLICY, d);
    rreg(ADR_FILL, 8'h00);
    rreg(ADR_EVT_FLAGS, 8'h00);
  endtask
  task automatic t_reset();
    rreg(ADR_POLICY, RST_POLICY);
    rreg(ADR_AXIS, 8'h00);
    rreg(ADR_IRQ_EN, 8'h00);
    rreg(ADR_IRQ_ROUTE, 8'h00);
    rreg(ADR_FILL, 8'h00);
    host.wr(ADR_EVT_FLAGS, 8'hFF);
    rreg(ADR_EVT_FLAGS, 8'h00);
    rreg(8'h30, 8'h00);
    pin_is(1'b0);
    @(posedge mclk);
    other_irq <= 1'b1;
    pin_is(1'b1);
    irq_act_high <= 1'b0;
    pin_is(1'b0);
    other_irq <= 1'b0;
    irq_act_high <= 1'b1;
  endtask
  task automatic t_stop();
    cfg(8'h44);
    push(63);
    rreg(ADR_EVT_FLAGS, 8'h02);
    push(2);
    rreg(ADR_FILL, 8'h40);
    rreg(ADR_EVT_FLAGS, 8'h06);
    host.rd(ADR_READ_PORT, 6);
    chk_smp(0, 8'h00);
    rreg(ADR_FILL, 8'h3F);
    host.wr(ADR_AXIS, 8'h00);
    rreg(ADR_FILL, 8'h00);
    rreg(ADR_EVT_FLAGS, 8'h00);
  endtask
  task automatic t_ovw();
    host.wr(ADR_IRQ_EN, 8'hFF);
    rreg(ADR_IRQ_EN, 8'h60);
    host.wr(ADR_IRQ_ROUTE, 8'h04);
    cfg(8'h80);
    push(62);
    pin_is(1'b0);
    push(1);
    pin_is(1'b1);
    push(8);
    rreg(ADR_FILL, 8'h40);
    host.rd(ADR_READ_PORT, 6);
    chk_smp(0, 8'h07);
    host.wr(ADR_IRQ_ROUTE, 8'h00);
    pin_is(1'b0);
    host.wr(ADR_IRQ_EN, 8'h00);
  endtask
  task automatic t_pass();
    cfg(8'h00);
    push(3);
    rreg(ADR_FILL, 8'h01);
    rreg(ADR_EVT_FLAGS, 8'h04);
    host.rd(ADR_READ_PORT, 12);
    chk_smp(0, 8'h02);
    for (int k = 6; k < 12; k++) chk(host.rb[k], 8'h00);
  endtask
  task automatic t_axis();
    cfg(8'h40);
    for (int s = 1; s < 4; s++) begin
      host.wr(ADR_AXIS, 8'(s));
      sn = 8'h00;
      push(1);
      host.rd(ADR_READ_PORT, 2);
      chk(host.rb[0], 8'h00);
      chk(host.rb[1], hi[s - 1]);
    end
    host.wr(ADR_AXIS, 8'h00);
    sn = 8'h00;
    push(2);
    host.rd(ADR_READ_PORT, 2);
    host.rd(ADR_READ_PORT, 6);
    chk_smp(0, 8'h01);
    rreg(ADR_FILL, 8'h00);
  endtask
  task automatic t_trig();
    cfg(8'hC3);
    push(10);
    trig();
    rreg(ADR_FILL, 8'h03);
    push(70);
    trig();
    rreg(ADR_FILL, 8'h40);
    host.rd(ADR_READ_PORT, 6);
    chk_smp(0, 8'h07);
    cfg(8'h00);
    cfg(8'hC3);
    push(5);
    trig();
    rreg(ADR_FILL, 8'h03);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_stop();
    t_ovw();
    t_pass();
    t_axis();
    t_trig();
    chk(host.nak, 8'h00);
    final_report();
  end
  initial begin
    #1500000;
    err_count++;
    final_report();
  end
endmodule // tb
